// *** hw/uopc_consts.svh ***
// Purpose: constants of the user otp program control block
// Assumes: 8-bit register port, 250 MHz core clock
// Notes: offsets are register addresses on the device register port
`ifndef UOPC_CONSTS_SVH
`define UOPC_CONSTS_SVH

// register addresses
`define UOPC_ADDR_WR_CTL 8'h11
`define UOPC_ADDR_UF2_BASE 8'h20
`define UOPC_ADDR_CHECK0 8'h30
`define UOPC_ADDR_CHECK1 8'h31
`define UOPC_ADDR_CHECK2 8'h32
`define UOPC_ADDR_CHG_ERR 8'h34
`define UOPC_ADDR_STATUS 8'h35
`define UOPC_ADDR_UF0_WIN 4'ha
`define UOPC_ADDR_UF1_WIN 4'hb

// otp_write_control fields
`define UOPC_CTL_TRIG_BIT 7
`define UOPC_CTL_EXCT_BIT 3
`define UOPC_CTL_EXPA_BIT 2
`define UOPC_CTL_REG_LSB 0
`define UOPC_CTL_WMASK 8'h8f
`define UOPC_CTL_RESET 8'h00

// region two byte positions
`define UOPC_UF2_CT_IDX 4'h0
`define UOPC_UF2_PA_IDX 4'h1

// check code
`define UOPC_CRC_POLY 7'h09
`define UOPC_CRC_INIT 7'h00

// timing
`define UOPC_CLK_NS 4
`define UOPC_BYTE_PROG_NS 100

`endif

// *** hw/uopc_otp_cells.sv ***
// Purpose: nonvolatile cell array model, three regions of sixteen bytes
// Assumes: one write and one read port, read data registered
// Notes: unprogrammed cells read zero
`timescale 1ns/10ps
module uopc_otp_cells #(
	parameter int AW = 6,
	parameter int DEPTH = 48
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [7:0] rd_data
);
	logic [7:0] cell_r [DEPTH];

	// cells only gain ones when burned
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				cell_r[i] <= 8'h00;
			end
		end else if (wr_en) begin
			cell_r[wr_addr] <= cell_r[wr_addr] | wr_data;
		end
	end

	// registered read
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= cell_r[rd_addr];
		end
	end

endmodule : uopc_otp_cells

// *** hw/uopc_pkg.sv ***
// Purpose: types of the user otp program control block
// Assumes: nothing beyond the consts header
// Notes: one-hot controller states
package uopc_pkg;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_CRC = 6'h02,
		ST_PROG = 6'h04,
		ST_PWAIT = 6'h08,
		ST_RLOAD = 6'h10,
		ST_RCAP = 6'h20
	} uopc_state_t;

	typedef enum logic [1:0] {
		REG_UF0 = 2'h0,
		REG_UF1 = 2'h1,
		REG_UF2 = 2'h2,
		REG_RSV = 2'h3
	} uopc_region_t;

endpackage : uopc_pkg

// *** hw/uopc_top.sv ***
// Purpose: user otp programming from mirror registers
// Assumes: register port driven by logic on clk_sys
// Notes: writes are ignored while a programming sequence runs
`timescale 1ns/10ps
`include "uopc_consts.svh"
module uopc_top #(
	parameter int BYTE_PROG_NS = `UOPC_BYTE_PROG_NS
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wr_data,
	output logic [7:0] reg_rd_data,
	output logic reg_rd_valid,
	output logic otp_busy,
	output logic [2:0] region_lock,
	output logic [2:0] region_change_err
);
	localparam int BYTE_CYC_I = (BYTE_PROG_NS + `UOPC_CLK_NS - 1) / `UOPC_CLK_NS;
	localparam int BYTE_CYC = (BYTE_CYC_I < 1) ? 1 : BYTE_CYC_I;
	localparam int WW = $clog2(BYTE_CYC + 1);
	localparam logic [WW-1:0] WAIT_LAST = WW'(BYTE_CYC - 1);

	uopc_pkg::uopc_state_t state_r;
	logic [7:0] otp_write_control_r;
	logic [7:0] shared_r [16];
	logic [7:0] uf2_r [16];
	logic shared_base_r;
	logic [6:0] crc_r [3];
	logic [6:0] crc_acc_r;
	logic [3:0] idx_r;
	logic [WW-1:0] wait_r;
	logic [1:0] tgt_r;
	logic tgt_ex_ct_r;
	logic tgt_ex_pa_r;
	logic [1:0] scan_reg_r;
	logic [3:0] scan_idx_r;
	logic scan_chk_r;
	logic [1:0] chk_reg_r;
	logic [3:0] chk_idx_r;
	logic [7:0] cell_rd;
	logic [5:0] cell_rd_addr;
	logic cell_wr;
	logic [7:0] src_byte;
	logic excl_byte;
	logic wr_ok;
	logic ctl_wr;
	logic trig_ok;
	logic [1:0] wsel;
	logic [3:0] win;
	logic [7:0] mirror_at_chk;

	assign wsel = reg_wr_data[`UOPC_CTL_REG_LSB +: 2];
	assign win = reg_addr[7:4];
	assign wr_ok = reg_wr_en && (state_r == uopc_pkg::ST_IDLE);
	assign ctl_wr = wr_ok && (reg_addr == `UOPC_ADDR_WR_CTL);
	// start only for a real, unlocked region
	assign trig_ok = ctl_wr && reg_wr_data[`UOPC_CTL_TRIG_BIT] && (wsel != uopc_pkg::REG_RSV) &&
		!region_lock[wsel];
	assign otp_busy = (state_r != uopc_pkg::ST_IDLE);

	// next check-code step, msb first
	function automatic logic [6:0] crc_step(input logic [6:0] c, input logic [7:0] d);
		logic [6:0] x;
		logic fb;
		x = c;
		for (int i = 7; i >= 0; i--) begin
			fb = x[6] ^ d[i];
			x = {x[5:0], 1'b0};
			if (fb) begin
				x = x ^ `UOPC_CRC_POLY;
			end
		end
		return x;
	endfunction : crc_step

	// byte to burn for the current target and index
	always_comb begin
		excl_byte = (tgt_r == uopc_pkg::REG_UF2) &&
			((tgt_ex_pa_r && idx_r == `UOPC_UF2_PA_IDX) ||
			(tgt_ex_ct_r && idx_r == `UOPC_UF2_CT_IDX));
		if (tgt_r == uopc_pkg::REG_UF2) begin
			src_byte = excl_byte ? 8'h00 : uf2_r[idx_r];
		end else begin
			src_byte = shared_r[idx_r];
		end
	end

	// control register, trigger stays set after programming
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			otp_write_control_r <= `UOPC_CTL_RESET;
		end else if (ctl_wr) begin
			otp_write_control_r <= reg_wr_data & `UOPC_CTL_WMASK;
		end
	end

	// target latched from the triggering write
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tgt_r <= 2'h0;
			tgt_ex_ct_r <= 1'b0;
			tgt_ex_pa_r <= 1'b0;
		end else if (trig_ok) begin
			tgt_r <= wsel;
			tgt_ex_ct_r <= reg_wr_data[`UOPC_CTL_EXCT_BIT];
			tgt_ex_pa_r <= reg_wr_data[`UOPC_CTL_EXPA_BIT];
		end
	end

	// shared mirror block and its base
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			shared_base_r <= 1'b0;
			for (int i = 0; i < 16; i++) begin
				shared_r[i] <= 8'h00;
			end
		end else if (wr_ok && (win == `UOPC_ADDR_UF0_WIN || win == `UOPC_ADDR_UF1_WIN)) begin
			shared_base_r <= (win == `UOPC_ADDR_UF1_WIN);
			shared_r[reg_addr[3:0]] <= reg_wr_data;
		end
	end

	// region two mirrors, written by port or by reload
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 16; i++) begin
				uf2_r[i] <= 8'h00;
			end
		end else if (state_r == uopc_pkg::ST_RCAP) begin
			if (!(tgt_ex_ct_r && idx_r == `UOPC_UF2_CT_IDX)) begin
				uf2_r[idx_r] <= cell_rd;
			end
		end else if (wr_ok && reg_addr[7:4] == 4'(`UOPC_ADDR_UF2_BASE >> 4)) begin
			uf2_r[reg_addr[3:0]] <= reg_wr_data;
		end
	end

	// programming sequence controller
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_r <= uopc_pkg::ST_IDLE;
			idx_r <= 4'h0;
			wait_r <= '0;
			crc_acc_r <= `UOPC_CRC_INIT;
		end else begin
			case (state_r)
				uopc_pkg::ST_IDLE: begin
					idx_r <= 4'h0;
					crc_acc_r <= `UOPC_CRC_INIT;
					if (trig_ok) begin
						state_r <= uopc_pkg::ST_CRC;
					end
				end
				uopc_pkg::ST_CRC: begin
					crc_acc_r <= crc_step(crc_acc_r, src_byte);
					idx_r <= idx_r + 4'h1;
					if (idx_r == 4'hf) begin
						state_r <= uopc_pkg::ST_PROG;
					end
				end
				uopc_pkg::ST_PROG: begin
					wait_r <= '0;
					state_r <= uopc_pkg::ST_PWAIT;
				end
				uopc_pkg::ST_PWAIT: begin
					wait_r <= wait_r + WW'(1);
					if (wait_r == WAIT_LAST) begin
						idx_r <= idx_r + 4'h1;
						if (idx_r != 4'hf) begin
							state_r <= uopc_pkg::ST_PROG;
						end else if (tgt_r == uopc_pkg::REG_UF2) begin
							state_r <= uopc_pkg::ST_RLOAD;
						end else begin
							state_r <= uopc_pkg::ST_IDLE;
						end
					end
				end
				uopc_pkg::ST_RLOAD: begin
					state_r <= uopc_pkg::ST_RCAP;
				end
				uopc_pkg::ST_RCAP: begin
					idx_r <= idx_r + 4'h1;
					state_r <= (idx_r == 4'hf) ? uopc_pkg::ST_IDLE : uopc_pkg::ST_RLOAD;
				end
				default: begin
					state_r <= uopc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// check code and lock stored once the last byte is burned
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			region_lock <= 3'h0;
			for (int i = 0; i < 3; i++) begin
				crc_r[i] <= `UOPC_CRC_INIT;
			end
		end else if (state_r == uopc_pkg::ST_PWAIT && wait_r == WAIT_LAST && idx_r == 4'hf) begin
			region_lock[tgt_r] <= 1'b1;
			crc_r[tgt_r] <= crc_acc_r;
		end
	end

	// cells written only by the controller, excluded bytes skipped
	assign cell_wr = (state_r == uopc_pkg::ST_PROG) && !excl_byte;
	assign cell_rd_addr = (state_r == uopc_pkg::ST_RLOAD) ? {uopc_pkg::REG_UF2, idx_r} :
		{scan_reg_r, scan_idx_r};

	uopc_otp_cells #(
		.AW(6),
		.DEPTH(48)
	) u_cells (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.wr_en(cell_wr),
		.wr_addr({tgt_r, idx_r}),
		.wr_data(src_byte),
		.rd_addr(cell_rd_addr),
		.rd_data(cell_rd)
	);

	// background scan of cells against mirrors
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			scan_reg_r <= 2'h0;
			scan_idx_r <= 4'h0;
			scan_chk_r <= 1'b0;
			chk_reg_r <= 2'h0;
			chk_idx_r <= 4'h0;
		end else begin
			scan_chk_r <= (state_r == uopc_pkg::ST_IDLE) && region_lock[scan_reg_r];
			chk_reg_r <= scan_reg_r;
			chk_idx_r <= scan_idx_r;
			if (state_r == uopc_pkg::ST_IDLE) begin
				scan_idx_r <= scan_idx_r + 4'h1;
				if (scan_idx_r == 4'hf) begin
					scan_reg_r <= (scan_reg_r == uopc_pkg::REG_UF2) ? 2'h0 : scan_reg_r + 2'h1;
				end
			end
		end
	end

	// mirror byte compared with the cell byte just read
	always_comb begin
		if (chk_reg_r == uopc_pkg::REG_UF2) begin
			mirror_at_chk = uf2_r[chk_idx_r];
			if ((tgt_ex_pa_r && chk_idx_r == `UOPC_UF2_PA_IDX) ||
				(tgt_ex_ct_r && chk_idx_r == `UOPC_UF2_CT_IDX)) begin
				mirror_at_chk = cell_rd; // excluded bytes not watched
			end
		end else if (chk_reg_r[0] == shared_base_r) begin
			mirror_at_chk = shared_r[chk_idx_r];
		end else begin
			mirror_at_chk = cell_rd; // other shared region not loaded
		end
	end

	// sticky change flags, cleared only by reset
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			region_change_err <= 3'h0;
		end else if (scan_chk_r && state_r == uopc_pkg::ST_IDLE && mirror_at_chk != cell_rd) begin
			region_change_err[chk_reg_r] <= 1'b1;
		end
	end

	// register read port, one cycle latency
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			reg_rd_data <= 8'h00;
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd_en;
			if (reg_rd_en) begin
				if (reg_addr == `UOPC_ADDR_WR_CTL) begin
					reg_rd_data <= otp_write_control_r;
				end else if (win == `UOPC_ADDR_UF0_WIN || win == `UOPC_ADDR_UF1_WIN) begin
					reg_rd_data <= shared_r[reg_addr[3:0]];
				end else if (reg_addr[7:4] == 4'(`UOPC_ADDR_UF2_BASE >> 4)) begin
					reg_rd_data <= uf2_r[reg_addr[3:0]];
				end else if (reg_addr >= `UOPC_ADDR_CHECK0 && reg_addr <= `UOPC_ADDR_CHECK2) begin
					reg_rd_data <= {region_lock[reg_addr[1:0]], crc_r[reg_addr[1:0]]};
				end else if (reg_addr == `UOPC_ADDR_CHG_ERR) begin
					reg_rd_data <= {5'h00, region_change_err};
				end else if (reg_addr == `UOPC_ADDR_STATUS) begin
					reg_rd_data <= {otp_busy, 6'h00, shared_base_r};
				end else begin
					reg_rd_data <= 8'h00;
				end
			end
		end
	end

endmodule : uopc_top

// *** tb/uopc_top_monitor.sv ***
// Purpose: port checker for uopc_top
// Assumes: bound to uopc_top, one clock domain
// Notes: lock and busy relations seen from the register port
`timescale 1ns/10ps
`include "uopc_consts.svh"
module uopc_top_monitor #(
	parameter int BYTE_PROG_NS = 4
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wr_data,
	input wire logic [7:0] reg_rd_data,
	input wire logic reg_rd_valid,
	input wire logic otp_busy,
	input wire logic [2:0] region_lock,
	input wire logic [2:0] region_change_err
);
	logic trig;
	logic trig_ok;
	logic [3:0] lk;

	// trigger write and whether its target may be burned
	assign lk = {1'b1, region_lock};
	assign trig = reg_wr_en && !otp_busy && reg_addr == `UOPC_ADDR_WR_CTL && reg_wr_data[7];
	assign trig_ok = trig && !lk[reg_wr_data[1:0]];

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	// programming starts on an accepted trigger only
	property p_start;
		trig_ok |=> otp_busy;
	endproperty
	a_start: assert property (p_start) else $error("trigger did not start programming");
	property p_idle;
		!otp_busy && !trig_ok |=> !otp_busy;
	endproperty
	a_idle: assert property (p_idle) else $error("programming without trigger");
	property p_refuse;
		trig && !trig_ok |=> !otp_busy && region_lock == $past(region_lock);
	endproperty
	a_refuse: assert property (p_refuse) else $error("refused trigger changed state");
	property p_done;
		$rose(otp_busy) |-> ##[16:1000] !otp_busy;
	endproperty
	a_done: assert property (p_done) else $error("programming never ended");
	// lock flags only rise, one at a time, while busy
	property p_sticky;
		(region_lock & $past(region_lock)) == $past(region_lock);
	endproperty
	a_sticky: assert property (p_sticky) else $error("lock flag cleared");
	property p_lock_busy;
		region_lock != $past(region_lock) |-> $past(otp_busy) && $onehot(region_lock ^ $past(region_lock));
	endproperty
	a_lock_busy: assert property (p_lock_busy) else $error("lock set outside programming");
	property p_end_lock;
		$fell(otp_busy) |-> region_lock != 3'h0;
	endproperty
	a_end_lock: assert property (p_end_lock) else $error("programming ended unlocked");
	property p_err;
		(region_change_err & ~region_lock) == 3'h0;
	endproperty
	a_err: assert property (p_err) else $error("change flag on unlocked region");
	property p_rd;
		reg_rd_valid == $past(reg_rd_en);
	endproperty
	a_rd: assert property (p_rd) else $error("read answer out of step");

	// main scenarios reached
	c_r2: cover property (trig_ok && reg_wr_data[1:0] == 2'h2);
	c_rsv: cover property (trig && reg_wr_data[1:0] == 2'h3);
	c_err: cover property ($rose(region_change_err[2]));
endmodule : uopc_top_monitor

bind uopc_top uopc_top_monitor #(.BYTE_PROG_NS(BYTE_PROG_NS)) uopc_top_monitor_i (.clk_sys(clk_sys),
	.resetn(resetn), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
	.reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
	.otp_busy(otp_busy), .region_lock(region_lock), .region_change_err(region_change_err));

// *** tb/uopc_top_tb_top.sv ***
// Purpose: register level test of uopc_top
// Assumes: strobes driven by nonblocking assignment on clk_sys
// Notes: one cycle byte programming keeps runs short
`timescale 1ns/10ps
`include "uopc_consts.svh"
module uopc_top_tb_top;
	logic clk_sys, resetn, reg_wr_en, reg_rd_en, reg_rd_valid, otp_busy;
	logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
	logic [2:0] region_lock, region_change_err;
	logic [7:0] m [16];
	logic [7:0] e [16];
	int fail_count, n_checks;

	uopc_top #(.BYTE_PROG_NS(4)) uopc_top_i (.clk_sys(clk_sys), .resetn(resetn), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
		.reg_rd_valid(reg_rd_valid), .otp_busy(otp_busy), .region_lock(region_lock),
		.region_change_err(region_change_err));

	// 250 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask : chk

	task automatic reset_dut;
		@(posedge clk_sys);
		resetn <= 1'b0;
		reg_wr_en <= 1'b0;
		reg_rd_en <= 1'b0;
		reg_addr <= 8'h00;
		reg_wr_data <= 8'h00;
		repeat (4) @(posedge clk_sys);
		resetn <= 1'b1;
	endtask : reset_dut

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_wr_en <= 1'b1;
		reg_addr <= a;
		reg_wr_data <= v;
		@(posedge clk_sys);
		reg_wr_en <= 1'b0;
	endtask : wr

	// read one register and compare
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd_en <= 1'b0;
		#1;
		chk({7'h0, reg_rd_valid}, 8'h01);
		chk(reg_rd_data, exp);
	endtask : rdc

	// trigger write, then bounded wait for idle
	task automatic prog(input logic [7:0] v, input logic busy_exp);
		wr(`UOPC_ADDR_WR_CTL, v);
		@(posedge clk_sys);
		#1;
		chk({7'h0, otp_busy}, {7'h0, busy_exp});
		for (int i = 0; i < 300 && otp_busy !== 1'b0; i++) begin
			@(posedge clk_sys);
			#1;
		end
		if (otp_busy !== 1'b0) begin
			fail_count++;
			complete_run();
		end
	endtask : prog

	// expected check register: lock set, crc7 msb first
	function automatic logic [7:0] code(input logic [7:0] b [16]);
		logic [6:0] c;
		c = 7'h00;
		for (int i = 0; i < 16; i++)
			for (int k = 7; k >= 0; k--)
				c = {c[5:0], 1'b0} ^ ((c[6] ^ b[i][k]) ? 7'h09 : 7'h00);
		return {1'b1, c};
	endfunction : code

	// main sequence
	initial begin
		fail_count = 0;
		n_checks = 0;
		// inputs defined from time zero, reset asserted before the first edge
		resetn = 1'b0;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 8'h00;
		reg_wr_data = 8'h00;
		reset_dut();
		for (int i = 0; i < 16; i++)
			m[i] = 8'h00;
		for (int i = 0; i < 4; i++) begin
			m[i] = 8'h13 + 8'(i);
			wr(8'ha0 + 8'(i), m[i]);
		end
		rdc(8'ha1, m[1]);
		chk({5'h0, region_lock}, 8'h00);
		rdc(`UOPC_ADDR_WR_CTL, 8'h00);
		rdc(8'h50, 8'h00);
		prog(8'h83, 1'b0);
		rdc(`UOPC_ADDR_WR_CTL, 8'h83);
		rdc(`UOPC_ADDR_CHECK0, 8'h00);
		prog(8'h8c, 1'b1);
		chk({5'h0, region_lock}, 8'h01);
		rdc(`UOPC_ADDR_WR_CTL, 8'h8c);
		rdc(`UOPC_ADDR_CHECK0, code(m));
		wr(8'hb0, 8'h6e);
		rdc(`UOPC_ADDR_STATUS, 8'h01);
		m[0] = 8'h6e;
		prog(8'h81, 1'b1);
		chk({5'h0, region_lock}, 8'h03);
		rdc(`UOPC_ADDR_CHECK1, code(m));
		prog(8'h80, 1'b0);
		chk({5'h0, region_lock}, 8'h03);
		chk({5'h0, region_change_err}, 8'h00);
		// region two under every exclusion setting
		for (int f = 0; f < 4; f++) begin
			reset_dut();
			wr(8'h20, 8'h5a);
			wr(8'h21, 8'h33);
			wr(8'h22, 8'h77);
			for (int i = 0; i < 16; i++)
				e[i] = 8'h00;
			e[0] = f[1] ? 8'h00 : 8'h5a;
			e[1] = f[0] ? 8'h00 : 8'h33;
			e[2] = 8'h77;
			rdc(`UOPC_ADDR_CHECK2, 8'h00);
			prog(8'h82 | 8'(f << 2), 1'b1);
			chk({5'h0, region_lock}, 8'h04);
			rdc(8'h21, e[1]);
			rdc(8'h20, 8'h5a);
			rdc(`UOPC_ADDR_CHECK2, code(e));
			chk({5'h0, region_change_err}, 8'h00);
			wr(8'h22, 8'h19);
			rdc(8'h22, 8'h19);
			// the scan visits each of the 48 cells once per 48 idle cycles
			for (int i = 0; i < 64 && region_change_err !== 3'h4; i++) begin
				@(posedge clk_sys);
				#1;
			end
			chk({5'h0, region_change_err}, 8'h04);
			if (region_change_err !== 3'h4)
				complete_run();
			rdc(`UOPC_ADDR_CHG_ERR, 8'h04);
			prog(8'h82, 1'b0);
			rdc(`UOPC_ADDR_CHECK2, code(e));
		end
		complete_run();
	end
endmodule : uopc_top_tb_top
